// File: ueil_pkg.sv
// Constants for the cell port error interrupt block.
// Shared by the top module and the testbench; no imports are used.
package ueil_pkg;
	// Register byte offsets
	localparam logic [11:0] OFF_CTRL = 12'h000;
	localparam logic [11:0] OFF_CLKCHK = 12'h014;
	localparam logic [11:0] OFF_EN = 12'h018;
	localparam logic [11:0] OFF_PEND = 12'h01c;
	// Enable and pending bit positions
	localparam int TX_CP = 18;
	localparam int TX_CF = 17;
	localparam int TX_QS = 16;
	localparam int RX_CP = 2;
	localparam int RX_CF = 1;
	localparam int RX_QS = 0;
	// Control bit positions
	localparam int CTRL_TX_EN = 16;
	localparam int CTRL_RX_EN = 0;
	// Clock check field positions and width
	localparam int CNT_W = 8;
	localparam int TX_CNT_LSB = 16;
	localparam int RX_CNT_LSB = 0;
	// Implemented bit masks
	localparam logic [31:0] IRQ_MASK = 32'h0007_0007;
	localparam logic [31:0] W1C_MASK = 32'h0006_0006;
	localparam logic [31:0] CTRL_MASK = 32'h0001_0001;
	localparam logic [31:0] CLKCHK_MASK = 32'h00ff_00ff;
	// Reset values
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] CLKCHK_RST = 32'h00ff_00ff;
	localparam logic [31:0] EN_RST = 32'h0000_0000;
	localparam logic [31:0] PEND_RST = 32'h0000_0000;
endpackage

// File: ueil_sync2.sv
// Two flip-flop synchroniser for one level from another clock domain.
// Assumes the input is free of glitches wider than it is slow.
`timescale 1ns/10ps
module ueil_sync2
(
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Level in and out
	input wire logic d,
	output logic q
);
	logic meta_r;
	logic q_r;

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			meta_r <= 1'b0;
			q_r <= 1'b0;
		end
		else
		begin
			meta_r <= d;
			q_r <= meta_r;
		end
	end

	assign q = q_r;
endmodule

// File: ueil_clk_watch.sv
// Edge finder and timeout counter for one interface clock.
// Assumes a synchronised copy of the clock and a check count on pclk.
`timescale 1ns/10ps
module ueil_clk_watch
#(
	parameter int CW = 8
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Watched clock and settings
	input wire logic clk_sync,
	input wire logic enable,
	input wire logic [CW-1:0] check_count,
	// Results
	output logic edge_seen,
	output logic absent,
	output logic failed,
	output logic fail_pulse
);
	logic prev_r, prev_nxt;
	logic [CW-1:0] cnt_r, cnt_nxt;
	logic edge_r, edge_nxt;
	logic absent_r, absent_nxt;
	logic failed_r, failed_nxt;
	logic pulse_r, pulse_nxt;
	logic rise;

	assign rise = clk_sync & ~prev_r;

	always_comb
	begin
		prev_nxt = clk_sync;
		edge_nxt = rise;
		// Counter parks at the limit so it cannot wrap past it
		if (rise)
			cnt_nxt = '0;
		else if (cnt_r != check_count)
			cnt_nxt = cnt_r + 1'b1;
		else
			cnt_nxt = cnt_r;
		// A zero count turns the check off
		if (rise || check_count == '0)
			absent_nxt = 1'b0;
		else if (cnt_r == check_count)
			absent_nxt = 1'b1;
		else
			absent_nxt = absent_r;
		failed_nxt = enable & absent_nxt;
		pulse_nxt = failed_nxt & ~failed_r;
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			prev_r <= 1'b0;
			cnt_r <= '0;
			edge_r <= 1'b0;
			absent_r <= 1'b0;
			failed_r <= 1'b0;
			pulse_r <= 1'b0;
		end
		else
		begin
			prev_r <= prev_nxt;
			cnt_r <= cnt_nxt;
			edge_r <= edge_nxt;
			absent_r <= absent_nxt;
			failed_r <= failed_nxt;
			pulse_r <= pulse_nxt;
		end
	end

	assign edge_seen = edge_r;
	assign absent = absent_r;
	assign failed = failed_r;
	assign fail_pulse = pulse_r;

	zero_count_off_a: assert property (@(posedge clk) disable iff (!rstn)
		(check_count == '0) |=> !failed)
		else $error("clock check failed with zero count");
	fail_needs_en_a: assert property (@(posedge clk) disable iff (!rstn)
		failed |-> $past(enable))
		else $error("clock failure flagged while disabled");
	edge_seen_a: assert property (@(posedge clk) disable iff (!rstn)
		rise |=> edge_seen ##1 !edge_seen)
		else $error("clock edge not reported as one pulse");
endmodule

// File: ueil_top.sv
// Error and status interrupt logic of the cell port, with its APB slave.
// Assumes interface clocks far slower than pclk and queue signals on pclk.
//
// Operation
// - Interrupt when any enabled condition pending
// - Write one clears clock bits; zero keeps
// - Stall bits read-only, cleared when stall ends
// - Transmit clock seen sets bit 18
// - Receive clock seen sets bit 2
// - Enabled transmit clock timeout sets bit 17
// - Enabled receive clock timeout sets bit 1
// - Full-queue write stall holds bit 16
// - Empty-queue read stall holds bit 0
// - Transmit enables at 18,17,16, reset zero
// - Receive enables at 2,1,0, reset zero
// - Reserved bits read zero, writes ignored
// - Timeout resets transmit port; zero count disables
// - Transmitter disabled holds port in reset
//
// Chosen here: the address map and the APB slave port.
`timescale 1ns/10ps
module ueil_top
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Interface clocks from the link
	input wire logic cell_tx_clock,
	input wire logic cell_rx_clock,
	// Queue status from the datapath
	input wire logic tx_queue_full,
	input wire logic tx_queue_write_req,
	input wire logic rx_queue_empty,
	input wire logic rx_queue_read_req,
	// Port control and interrupt
	output logic transmitter_enable,
	output logic receiver_enable,
	output logic tx_port_reset,
	output logic rx_port_reset,
	output logic cell_port_irq
);
	logic [31:0] ctrl_r, ctrl_nxt;
	logic [31:0] clkchk_r, clkchk_nxt;
	logic [31:0] error_irq_enable_reg_r, error_irq_enable_reg_nxt;
	logic [31:0] error_irq_pending_reg_r, error_irq_pending_reg_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	logic pready_r, pready_nxt;
	logic pslverr_r, pslverr_nxt;
	logic tx_rst_r, tx_rst_nxt;
	logic rx_rst_r, rx_rst_nxt;
	logic irq_r, irq_nxt;
	logic tx_clk_s, rx_clk_s;
	logic tx_edge, tx_absent, tx_failed, tx_fail_pulse;
	logic rx_edge, rx_absent, rx_failed, rx_fail_pulse;
	logic wr_access;
	logic wr_ctrl, wr_clkchk, wr_en, wr_pend;
	logic [31:0] w1c;
	logic [ueil_pkg::CNT_W-1:0] tx_clk_check_count, rx_clk_check_count;

	function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
		hit = (a == off);
	endfunction

	function automatic logic mapped(input logic [11:0] a);
		mapped = hit(a, ueil_pkg::OFF_CTRL) | hit(a, ueil_pkg::OFF_CLKCHK) |
			hit(a, ueil_pkg::OFF_EN) | hit(a, ueil_pkg::OFF_PEND);
	endfunction

	assign tx_clk_check_count = clkchk_r[ueil_pkg::TX_CNT_LSB +: ueil_pkg::CNT_W];
	assign rx_clk_check_count = clkchk_r[ueil_pkg::RX_CNT_LSB +: ueil_pkg::CNT_W];

	ueil_sync2 u_tx_sync
	(
		.clk(pclk),
		.rstn(presetn),
		.d(cell_tx_clock),
		.q(tx_clk_s)
	);

	ueil_sync2 u_rx_sync
	(
		.clk(pclk),
		.rstn(presetn),
		.d(cell_rx_clock),
		.q(rx_clk_s)
	);

	ueil_clk_watch #(.CW(ueil_pkg::CNT_W)) u_tx_watch
	(
		.clk(pclk),
		.rstn(presetn),
		.clk_sync(tx_clk_s),
		.enable(ctrl_r[ueil_pkg::CTRL_TX_EN]),
		.check_count(tx_clk_check_count),
		.edge_seen(tx_edge),
		.absent(tx_absent),
		.failed(tx_failed),
		.fail_pulse(tx_fail_pulse)
	);

	ueil_clk_watch #(.CW(ueil_pkg::CNT_W)) u_rx_watch
	(
		.clk(pclk),
		.rstn(presetn),
		.clk_sync(rx_clk_s),
		.enable(ctrl_r[ueil_pkg::CTRL_RX_EN]),
		.check_count(rx_clk_check_count),
		.edge_seen(rx_edge),
		.absent(rx_absent),
		.failed(rx_failed),
		.fail_pulse(rx_fail_pulse)
	);

	// Writes land at the access edge; unmapped writes are dropped
	assign wr_access = psel & penable & pready_r & pwrite & ~pslverr_r;
	assign wr_ctrl = wr_access & hit(paddr, ueil_pkg::OFF_CTRL);
	assign wr_clkchk = wr_access & hit(paddr, ueil_pkg::OFF_CLKCHK);
	assign wr_en = wr_access & hit(paddr, ueil_pkg::OFF_EN);
	assign wr_pend = wr_access & hit(paddr, ueil_pkg::OFF_PEND);
	assign w1c = wr_pend ? (pwdata & ueil_pkg::W1C_MASK) : 32'h0000_0000;

	// Register group
	always_comb
	begin
		ctrl_nxt = ctrl_r;
		clkchk_nxt = clkchk_r;
		error_irq_enable_reg_nxt = error_irq_enable_reg_r;
		if (wr_ctrl)
			ctrl_nxt = pwdata & ueil_pkg::CTRL_MASK;
		if (wr_clkchk)
			clkchk_nxt = pwdata & ueil_pkg::CLKCHK_MASK;
		if (wr_en)
			error_irq_enable_reg_nxt = pwdata & ueil_pkg::IRQ_MASK;
		// Clear first, then hardware sets override it
		error_irq_pending_reg_nxt = error_irq_pending_reg_r & ~w1c;
		if (tx_absent)
			error_irq_pending_reg_nxt[ueil_pkg::TX_CP] = 1'b0;
		if (rx_absent)
			error_irq_pending_reg_nxt[ueil_pkg::RX_CP] = 1'b0;
		if (tx_edge)
			error_irq_pending_reg_nxt[ueil_pkg::TX_CP] = 1'b1;
		if (rx_edge)
			error_irq_pending_reg_nxt[ueil_pkg::RX_CP] = 1'b1;
		if (tx_fail_pulse)
			error_irq_pending_reg_nxt[ueil_pkg::TX_CF] = 1'b1;
		if (rx_fail_pulse)
			error_irq_pending_reg_nxt[ueil_pkg::RX_CF] = 1'b1;
		// Stall bits follow the live condition, software cannot touch them
		error_irq_pending_reg_nxt[ueil_pkg::TX_QS] =
			tx_queue_write_req & tx_queue_full;
		error_irq_pending_reg_nxt[ueil_pkg::RX_QS] =
			rx_queue_read_req & rx_queue_empty;
		error_irq_pending_reg_nxt = error_irq_pending_reg_nxt & ueil_pkg::IRQ_MASK;
		// Using next values keeps the interrupt in step with its pending bit
		irq_nxt = |(error_irq_pending_reg_nxt & error_irq_enable_reg_nxt);
		tx_rst_nxt = ~ctrl_nxt[ueil_pkg::CTRL_TX_EN] | tx_failed;
		rx_rst_nxt = ~ctrl_nxt[ueil_pkg::CTRL_RX_EN] | rx_failed;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_r <= ueil_pkg::CTRL_RST;
			clkchk_r <= ueil_pkg::CLKCHK_RST;
			error_irq_enable_reg_r <= ueil_pkg::EN_RST;
			error_irq_pending_reg_r <= ueil_pkg::PEND_RST;
			irq_r <= 1'b0;
			tx_rst_r <= 1'b1;
			rx_rst_r <= 1'b1;
		end
		else
		begin
			ctrl_r <= ctrl_nxt;
			clkchk_r <= clkchk_nxt;
			error_irq_enable_reg_r <= error_irq_enable_reg_nxt;
			error_irq_pending_reg_r <= error_irq_pending_reg_nxt;
			irq_r <= irq_nxt;
			tx_rst_r <= tx_rst_nxt;
			rx_rst_r <= rx_rst_nxt;
		end
	end

	// Bus answer group: ready rises in the first access cycle
	always_comb
	begin
		pready_nxt = psel & ~penable;
		pslverr_nxt = psel & ~penable & ~mapped(paddr);
		prdata_nxt = prdata_r;
		if (psel && !penable)
		begin
			prdata_nxt = 32'h0000_0000;
			if (!pwrite)
			begin
				if (hit(paddr, ueil_pkg::OFF_CTRL))
					prdata_nxt = ctrl_r;
				else if (hit(paddr, ueil_pkg::OFF_CLKCHK))
					prdata_nxt = clkchk_r;
				else if (hit(paddr, ueil_pkg::OFF_EN))
					prdata_nxt = error_irq_enable_reg_r;
				else if (hit(paddr, ueil_pkg::OFF_PEND))
					prdata_nxt = error_irq_pending_reg_r;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata_r <= 32'h0000_0000;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end
		else
		begin
			prdata_r <= prdata_nxt;
			pready_r <= pready_nxt;
			pslverr_r <= pslverr_nxt;
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign transmitter_enable = ctrl_r[ueil_pkg::CTRL_TX_EN];
	assign receiver_enable = ctrl_r[ueil_pkg::CTRL_RX_EN];
	assign tx_port_reset = tx_rst_r;
	assign rx_port_reset = rx_rst_r;
	assign cell_port_irq = irq_r;

	irq_combine_a: assert property (@(posedge pclk) disable iff (!presetn)
		cell_port_irq == |(error_irq_pending_reg_r & error_irq_enable_reg_r))
		else $error("interrupt does not match enabled pending bits");
	w1c_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_pend && pwdata[ueil_pkg::TX_CP] && !tx_edge)
		|=> !error_irq_pending_reg_r[ueil_pkg::TX_CP])
		else $error("write one did not clear clock present bit");
	w0_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_pend && !pwdata[ueil_pkg::RX_CF] && error_irq_pending_reg_r[ueil_pkg::RX_CF])
		|=> error_irq_pending_reg_r[ueil_pkg::RX_CF])
		else $error("write zero changed clock failed bit");
	set_wins_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_pend && pwdata[ueil_pkg::RX_CP] && rx_edge)
		|=> error_irq_pending_reg_r[ueil_pkg::RX_CP])
		else $error("clear won over hardware set");
	tx_stall_a: assert property (@(posedge pclk) disable iff (!presetn)
		(tx_queue_write_req && tx_queue_full) |=> error_irq_pending_reg_r[ueil_pkg::TX_QS])
		else $error("transmit stall not flagged");
	rx_stall_end_a: assert property (@(posedge pclk) disable iff (!presetn)
		!(rx_queue_read_req && rx_queue_empty) |=> !error_irq_pending_reg_r[ueil_pkg::RX_QS])
		else $error("receive stall bit not cleared");
	rsv_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
		(pready && !pwrite && (hit(paddr, ueil_pkg::OFF_EN) || hit(paddr, ueil_pkg::OFF_PEND)))
		|-> ((prdata & ~ueil_pkg::IRQ_MASK) == 32'h0000_0000))
		else $error("reserved bits read nonzero");
	fail_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
		tx_fail_pulse |=> error_irq_pending_reg_r[ueil_pkg::TX_CF] && tx_port_reset)
		else $error("transmit clock failure not flagged");
	tx_off_rst_a: assert property (@(posedge pclk) disable iff (!presetn)
		!transmitter_enable |-> tx_port_reset)
		else $error("disabled transmitter not in reset");
	ready_next_a: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && !penable) |=> pready)
		else $error("no ready in first access cycle");
	tx_stall_end_a: assert property (@(posedge pclk) disable iff (!presetn)
		!(tx_queue_write_req && tx_queue_full) |=> !error_irq_pending_reg_r[ueil_pkg::TX_QS])
		else $error("transmit stall bit not cleared");
	rx_stall_a: assert property (@(posedge pclk) disable iff (!presetn)
		(rx_queue_read_req && rx_queue_empty) |=> error_irq_pending_reg_r[ueil_pkg::RX_QS])
		else $error("receive stall not flagged");
	rx_fail_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
		rx_fail_pulse |=> error_irq_pending_reg_r[ueil_pkg::RX_CF] && rx_port_reset)
		else $error("receive clock failure not flagged");
	tx_present_a: assert property (@(posedge pclk) disable iff (!presetn)
		tx_edge |=> error_irq_pending_reg_r[ueil_pkg::TX_CP])
		else $error("transmit clock edge did not set present bit");
	rx_present_a: assert property (@(posedge pclk) disable iff (!presetn)
		rx_edge |=> error_irq_pending_reg_r[ueil_pkg::RX_CP])
		else $error("receive clock edge did not set present bit");
	tx_absent_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
		(tx_absent && !tx_edge) |=> !error_irq_pending_reg_r[ueil_pkg::TX_CP])
		else $error("absent transmit clock still reads present");
	rx_absent_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
		(rx_absent && !rx_edge) |=> !error_irq_pending_reg_r[ueil_pkg::RX_CP])
		else $error("absent receive clock still reads present");
	cf_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_pend && pwdata[ueil_pkg::TX_CF] && !tx_fail_pulse)
		|=> !error_irq_pending_reg_r[ueil_pkg::TX_CF])
		else $error("write one did not clear clock failed bit");
	rx_off_rst_a: assert property (@(posedge pclk) disable iff (!presetn)
		!receiver_enable |-> rx_port_reset)
		else $error("disabled receiver not in reset");
endmodule

// File: ueil_link_model.sv
// Link-side master model: makes the transmit and receive interface clocks.
// Assumes the bench starts and stops each clock through its run input.
`timescale 1ns/10ps
module ueil_link_model
(
	// Run controls from the bench
	input wire logic tx_run,
	input wire logic rx_run,
	// Interface clocks
	output logic cell_tx_clock,
	output logic cell_rx_clock
);
	// Odd start offsets keep link edges off the pclk edges
	initial
	begin
		cell_tx_clock = 1'b0;
		#7;
		forever #24 cell_tx_clock = tx_run ? ~cell_tx_clock : 1'b0;
	end
	// A stopped clock rests low, as a master that has ceased clocking
	initial
	begin
		cell_rx_clock = 1'b0;
		#13;
		forever #24 cell_rx_clock = rx_run ? ~cell_rx_clock : 1'b0;
	end
endmodule

// File: tb_top.sv
// Self-checking bench for the cell port error interrupt block.
// Assumes the link model for the clocks and bench-driven queue status.
`timescale 1ns/10ps
module tb_top;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic pready;
	logic pslverr;
	logic er;
	logic tx_run = 1'b0;
	logic rx_run = 1'b0;
	logic cell_tx_clock;
	logic cell_rx_clock;
	logic tx_queue_full = 1'b0;
	logic tx_queue_write_req = 1'b0;
	logic rx_queue_empty = 1'b0;
	logic rx_queue_read_req = 1'b0;
	logic transmitter_enable;
	logic receiver_enable;
	logic tx_port_reset;
	logic rx_port_reset;
	logic cell_port_irq;
	int n_errors = 0;
	int cmp_count = 0;
	int cyc = 0;

	always #2 pclk = ~pclk;

	ueil_link_model link (.tx_run(tx_run), .rx_run(rx_run),
		.cell_tx_clock(cell_tx_clock), .cell_rx_clock(cell_rx_clock));

	ueil_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .cell_tx_clock(cell_tx_clock),
		.cell_rx_clock(cell_rx_clock), .tx_queue_full(tx_queue_full),
		.tx_queue_write_req(tx_queue_write_req), .rx_queue_empty(rx_queue_empty),
		.rx_queue_read_req(rx_queue_read_req), .transmitter_enable(transmitter_enable),
		.receiver_enable(receiver_enable), .tx_port_reset(tx_port_reset),
		.rx_port_reset(rx_port_reset), .cell_port_irq(cell_port_irq));

	task finish_test();
		$display("errors %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// The whole run needs under 600 cycles; a hang stops well past that
	always @(posedge pclk)
	begin
		cyc = cyc + 1;
		if (cyc == 20000)
		begin
			n_errors = n_errors + 1;
			finish_test();
		end
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count = cmp_count + 1;
		if (got !== exp)
		begin
			n_errors = n_errors + 1;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	task chkb(input logic got, input logic exp);
		chk({31'h0, got}, {31'h0, exp});
	endtask

	// Request held until pready is seen high at a rising edge
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task rdchk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask

	task s_regs();
		rdchk(ueil_pkg::OFF_CTRL, 32'h0000_0000);
		rdchk(ueil_pkg::OFF_CLKCHK, ueil_pkg::CLKCHK_RST);
		wr(ueil_pkg::OFF_CLKCHK, 32'hffff_ffff);
		rdchk(ueil_pkg::OFF_CLKCHK, 32'h00ff_00ff);
		rdchk(ueil_pkg::OFF_EN, 32'h0000_0000);
		rdchk(ueil_pkg::OFF_PEND, 32'h0000_0000);
		wr(ueil_pkg::OFF_EN, 32'hffff_ffff);
		rdchk(ueil_pkg::OFF_EN, 32'h0007_0007);
		wr(ueil_pkg::OFF_PEND, 32'hffff_ffff);
		rdchk(ueil_pkg::OFF_PEND, 32'h0000_0000);
		apb(1'b0, 12'h004, 32'h0);
		chkb(er, 1'b1);
		wr(ueil_pkg::OFF_EN, 32'h0000_0000);
	endtask

	// Zero check count keeps the present bits after the clocks stop
	task s_present();
		wr(ueil_pkg::OFF_CLKCHK, 32'h0000_0000);
		wr(ueil_pkg::OFF_CTRL, 32'h0001_0001);
		tx_run <= 1'b1;
		rx_run <= 1'b1;
		repeat (40) @(posedge pclk);
		// Clears every 5 cycles meet the 12-cycle receive edge in every phase
		repeat (12)
		begin
			wr(ueil_pkg::OFF_PEND, 32'h0000_0004);
			repeat (2) @(posedge pclk);
		end
		repeat (40) @(posedge pclk);
		tx_run <= 1'b0;
		rx_run <= 1'b0;
		repeat (60) @(posedge pclk);
		rdchk(ueil_pkg::OFF_PEND, 32'h0004_0004);
		chkb(tx_port_reset, 1'b0);
		wr(ueil_pkg::OFF_PEND, 32'h0000_0000);
		rdchk(ueil_pkg::OFF_PEND, 32'h0004_0004);
		wr(ueil_pkg::OFF_PEND, 32'h0004_0004);
		rdchk(ueil_pkg::OFF_PEND, 32'h0000_0000);
	endtask

	task s_fail();
		wr(ueil_pkg::OFF_CLKCHK, 32'h0014_0014);
		wr(ueil_pkg::OFF_CTRL, 32'h0000_0001);
		tx_run <= 1'b1;
		rx_run <= 1'b1;
		repeat (40) @(posedge pclk);
		chkb(transmitter_enable, 1'b0);
		chkb(receiver_enable, 1'b1);
		chkb(tx_port_reset, 1'b1);
		chkb(rx_port_reset, 1'b0);
		tx_run <= 1'b0;
		rx_run <= 1'b0;
		repeat (60) @(posedge pclk);
		rdchk(ueil_pkg::OFF_PEND, 32'h0000_0002);
		wr(ueil_pkg::OFF_PEND, 32'h0000_0000);
		rdchk(ueil_pkg::OFF_PEND, 32'h0000_0002);
		wr(ueil_pkg::OFF_CTRL, 32'h0001_0001);
		tx_run <= 1'b1;
		rx_run <= 1'b1;
		repeat (40) @(posedge pclk);
		chkb(tx_port_reset, 1'b0);
		tx_run <= 1'b0;
		rx_run <= 1'b0;
		repeat (60) @(posedge pclk);
		rdchk(ueil_pkg::OFF_PEND, 32'h0002_0002);
		chkb(tx_port_reset, 1'b1);
		chkb(rx_port_reset, 1'b1);
	endtask

	task s_irq();
		wr(ueil_pkg::OFF_EN, 32'h0000_0004);
		repeat (2) @(posedge pclk);
		chkb(cell_port_irq, 1'b0);
		wr(ueil_pkg::OFF_EN, 32'h0002_0000);
		repeat (2) @(posedge pclk);
		chkb(cell_port_irq, 1'b1);
		wr(ueil_pkg::OFF_PEND, 32'h0002_0002);
		repeat (2) @(posedge pclk);
		chkb(cell_port_irq, 1'b0);
		rdchk(ueil_pkg::OFF_PEND, 32'h0000_0000);
	endtask

	task s_stall();
		wr(ueil_pkg::OFF_EN, 32'h0001_0001);
		tx_queue_full <= 1'b1;
		tx_queue_write_req <= 1'b1;
		repeat (3) @(posedge pclk);
		chkb(cell_port_irq, 1'b1);
		wr(ueil_pkg::OFF_PEND, 32'h0001_0001);
		rdchk(ueil_pkg::OFF_PEND, 32'h0001_0000);
		tx_queue_full <= 1'b0;
		repeat (3) @(posedge pclk);
		rdchk(ueil_pkg::OFF_PEND, 32'h0000_0000);
		tx_queue_write_req <= 1'b0;
		rx_queue_empty <= 1'b1;
		rx_queue_read_req <= 1'b1;
		repeat (3) @(posedge pclk);
		rdchk(ueil_pkg::OFF_PEND, 32'h0000_0001);
		chkb(cell_port_irq, 1'b1);
		rx_queue_empty <= 1'b0;
		repeat (3) @(posedge pclk);
		rdchk(ueil_pkg::OFF_PEND, 32'h0000_0000);
		chkb(cell_port_irq, 1'b0);
		rx_queue_read_req <= 1'b0;
	endtask

	initial
	begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		s_regs();
		s_present();
		s_fail();
		s_irq();
		s_stall();
		finish_test();
	end
endmodule
